// *** logic/hfx_pkg.sv ***
// Constants shared by the host-side device-to-host frame transport block
package hfx_pkg;
    // ----------------------------------------------------------------
    // Frame type codes and lengths in doublewords
    // ----------------------------------------------------------------
    localparam logic [7:0] HFX_TYPE_REG_D2H = 8'h34;
    localparam logic [7:0] HFX_TYPE_SET_BITS = 8'ha1;
    localparam logic [7:0] HFX_TYPE_DMA_ACT = 8'h39;
    localparam logic [2:0] HFX_LEN_REG_D2H = 3'h5;
    localparam logic [2:0] HFX_LEN_SET_BITS = 3'h2;
    localparam logic [2:0] HFX_LEN_DMA_ACT = 3'h1;
    localparam logic [2:0] HFX_MAX_WORDS = 3'h5;
    localparam int HFX_WORDS = 5;

    // ----------------------------------------------------------------
    // Field positions inside the frame doublewords and the status byte
    // ----------------------------------------------------------------
    localparam int HFX_TYPE_LSB = 0;
    localparam int HFX_INT_BIT = 14;
    localparam int HFX_STATUS_LSB = 16;
    localparam int HFX_ERROR_LSB = 24;
    localparam int HFX_BYTE0_LSB = 0;
    localparam int HFX_BYTE1_LSB = 8;
    localparam int HFX_BYTE2_LSB = 16;
    localparam int HFX_BYTE3_LSB = 24;
    localparam int HFX_LOW_FIELD_LSB = 16;
    localparam int HFX_HIGH_FIELD_LSB = 20;
    localparam int HFX_BUSY_BIT = 7;
    localparam int HFX_DRQ_BIT = 3;
    localparam logic [7:0] HFX_SET_BITS_MASK = 8'h77;
    localparam logic [7:0] HFX_STATUS_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Controller register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] HFX_REG_STATUS = 8'h00;
    localparam logic [7:0] HFX_REG_ALT_STATUS = 8'h04;
    localparam logic [7:0] HFX_REG_ERROR = 8'h08;
    localparam logic [7:0] HFX_REG_ADDRESS = 8'h0c;
    localparam logic [7:0] HFX_REG_ADDRESS_EXP = 8'h10;
    localparam logic [7:0] HFX_REG_COUNT = 8'h14;
    localparam logic [7:0] HFX_REG_CONTROL = 8'h18;
    localparam logic [7:0] HFX_REG_FLAGS = 8'h1c;
    localparam logic [7:0] HFX_REG_REFUSED = 8'h20;
    localparam int HFX_CTL_ARM_BIT = 0;
    localparam int HFX_CTL_CLR_INT_BIT = 1;

    // ----------------------------------------------------------------
    // Frame collector states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        HFX_AS_IDLE = 2'b01,
        HFX_AS_FRAME = 2'b10
    } hfx_asm_state_t;
endpackage : hfx_pkg

// *** logic/hfx_frame_collector.sv ***
// Collects the doublewords of one received frame into a small store
`timescale 1ns/1ns
`default_nettype none
module hfx_frame_collector
    import hfx_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Frame stream from the link
    input wire logic rxValid,
    input wire logic rxSof,
    input wire logic rxEof,
    input wire logic [31:0] rxData,
    // Collected frame
    output logic frameDone,
    output logic [2:0] frameLen,
    output logic frameOver,
    output logic [31:0] frameWord [HFX_WORDS]
);
    hfx_asm_state_t state, next_state;
    logic [2:0] count, next_count;
    logic over, next_over;
    logic next_frameDone;
    logic [2:0] next_frameLen;
    logic next_frameOver;
    logic [31:0] next_frameWord [HFX_WORDS];

    always_comb begin
        next_state = state;
        next_count = count;
        next_over = over;
        next_frameDone = 1'b0;
        next_frameLen = frameLen;
        next_frameOver = frameOver;
        next_frameWord = frameWord;
        case (state)
            HFX_AS_IDLE: begin
                if (rxValid && rxSof) begin
                    next_frameWord[0] = rxData;
                    next_count = 3'h1;
                    next_over = 1'b0;
                    next_state = HFX_AS_FRAME;
                end
            end
            HFX_AS_FRAME: begin
                if (rxValid && rxSof) begin
                    next_frameWord[0] = rxData;
                    next_count = 3'h1;
                    next_over = 1'b0;
                end else if (rxValid) begin
                    if (count < HFX_MAX_WORDS) begin
                        next_frameWord[count] = rxData;
                        next_count = count + 3'h1;
                    end else begin
                        next_over = 1'b1;
                    end
                end
            end
            default: begin
                next_state = HFX_AS_IDLE;
            end
        endcase
        // A frame ends on its end marker, even a one-word frame
        if (rxValid && rxEof && (rxSof || state == HFX_AS_FRAME)) begin
            next_frameDone = 1'b1;
            next_frameLen = next_count;
            next_frameOver = next_over;
            next_state = HFX_AS_IDLE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= HFX_AS_IDLE;
            count <= 3'h0;
            over <= 1'b0;
            frameDone <= 1'b0;
            frameLen <= 3'h0;
            frameOver <= 1'b0;
            for (int i = 0; i < HFX_WORDS; i++) begin
                frameWord[i] <= 32'h0;
            end
        end else begin
            state <= next_state;
            count <= next_count;
            over <= next_over;
            frameDone <= next_frameDone;
            frameLen <= next_frameLen;
            frameOver <= next_frameOver;
            frameWord <= next_frameWord;
        end
    end

    AST_OVER_MARKS_LONG: assert property (@(posedge clk) disable iff (rst)
        (frameDone && !frameOver) |-> (frameLen <= HFX_MAX_WORDS && frameLen != 3'h0))
        else $error("collected frame length out of range");
endmodule : hfx_frame_collector
`default_nettype wire

// *** logic/hfx_dma_launcher.sv ***
// Turns device activations and software arming into host data frame requests
`timescale 1ns/1ns
`default_nettype none
module hfx_dma_launcher (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Events
    input wire logic actEvent,
    input wire logic armWrite,
    input wire logic dataFisAck,
    // State
    output logic dataFisReq,
    output logic armed,
    output logic actPending
);
    logic launch;
    logic next_dataFisReq, next_armed, next_actPending;

    always_comb begin
        launch = (actPending || actEvent) && (armed || armWrite) && !dataFisReq;
        next_dataFisReq = (dataFisReq && !dataFisAck) || launch;
        next_armed = (armed || armWrite) && !launch;
        next_actPending = (actPending || actEvent) && !launch;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dataFisReq <= 1'b0;
            armed <= 1'b0;
            actPending <= 1'b0;
        end else begin
            dataFisReq <= next_dataFisReq;
            armed <= next_armed;
            actPending <= next_actPending;
        end
    end

    AST_ARMED_ACT_SENDS: assert property (@(posedge clk) disable iff (rst)
        (actEvent && armed && !dataFisReq) |=> (dataFisReq && !armed))
        else $error("armed activation did not start a data frame");
    AST_LATE_ARM_SENDS: assert property (@(posedge clk) disable iff (rst)
        (actPending && !armed && armWrite && !dataFisReq) |=> (dataFisReq && !actPending))
        else $error("pending activation not served on arming");
    AST_DATA_NEEDS_ACT: assert property (@(posedge clk) disable iff (rst)
        $rose(dataFisReq) |-> ($past(actPending) || $past(actEvent)))
        else $error("data frame requested without activation");
endmodule : hfx_dma_launcher
`default_nettype wire

// *** logic/hfx_host_transport.sv ***
// Host transport end for device-to-host register, set-bits and activate frames
`timescale 1ns/1ns
`default_nettype none
module hfx_host_transport
    import hfx_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Frame stream from the link
    input wire logic rxValid,
    input wire logic rxSof,
    input wire logic rxEof,
    input wire logic [31:0] rxData,
    // End-of-frame handshake to the link
    output logic rxOk,
    output logic rxErr,
    // Host data frame request
    output logic dataFisReq,
    input wire logic dataFisAck,
    // Interrupt pending state
    output logic intPending,
    // Software register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata
);
    // ----------------------------------------------------------------
    // Frame collection
    // ----------------------------------------------------------------
    logic frameDone;
    logic [2:0] frameLen;
    logic frameOver;
    logic [31:0] frameWord [HFX_WORDS];

    hfx_frame_collector u_collector (
        .clk(clk),
        .rst(rst),
        .rxValid(rxValid),
        .rxSof(rxSof),
        .rxEof(rxEof),
        .rxData(rxData),
        .frameDone(frameDone),
        .frameLen(frameLen),
        .frameOver(frameOver),
        .frameWord(frameWord)
    );

    // ----------------------------------------------------------------
    // Frame decoding
    // ----------------------------------------------------------------
    function automatic logic isFrame(input logic [31:0] w0, input logic [2:0] len, input logic over,
                                     input logic [7:0] code, input logic [2:0] want);
        isFrame = (w0[HFX_TYPE_LSB +: 8] == code) && (len == want) && !over;
    endfunction : isFrame

    function automatic logic [7:0] fieldByte(input logic [31:0] w, input int lsb);
        fieldByte = w[lsb +: 8];
    endfunction : fieldByte

    // Shadow copies are read by the decoder, so they are declared here
    logic [7:0] status, altStatus, shadowError, lbaLow, lbaMid, lbaHigh, device;
    logic isReg, isSetBits, isAct, frameGood, shadowIdle;
    logic regApply, setBitsApply, actEvent;
    logic [7:0] setBitsStatus;

    always_comb begin
        isReg = isFrame(frameWord[0], frameLen, frameOver, HFX_TYPE_REG_D2H, HFX_LEN_REG_D2H);
        isSetBits = isFrame(frameWord[0], frameLen, frameOver, HFX_TYPE_SET_BITS, HFX_LEN_SET_BITS);
        isAct = isFrame(frameWord[0], frameLen, frameOver, HFX_TYPE_DMA_ACT, HFX_LEN_DMA_ACT);
        frameGood = isReg || isSetBits || isAct;
        shadowIdle = !status[HFX_BUSY_BIT] && !status[HFX_DRQ_BIT];
        regApply = frameDone && isReg && !shadowIdle;
        setBitsApply = frameDone && isSetBits;
        actEvent = frameDone && isAct;
        // Status bits 6..4 and 2..0 come from the two fields; bits 7 and 3 kept
        setBitsStatus = {1'b0, frameWord[0][HFX_HIGH_FIELD_LSB +: 3], 1'b0,
                         frameWord[0][HFX_LOW_FIELD_LSB +: 3]};
    end

    // ----------------------------------------------------------------
    // Shadow command and control block
    // ----------------------------------------------------------------
    logic [7:0] lbaLowExp, lbaMidExp, lbaHighExp, secCount, secCountExp;
    logic [7:0] next_status, next_altStatus, next_shadowError, next_lbaLow, next_lbaMid;
    logic [7:0] next_lbaHigh, next_device, next_lbaLowExp, next_lbaMidExp, next_lbaHighExp;
    logic [7:0] next_secCount, next_secCountExp;
    logic swStatusWrite;

    always_comb begin
        swStatusWrite = regWr && (regAddr == HFX_REG_STATUS);
        next_status = status;
        next_altStatus = altStatus;
        next_shadowError = shadowError;
        next_lbaLow = lbaLow;
        next_lbaMid = lbaMid;
        next_lbaHigh = lbaHigh;
        next_device = device;
        next_lbaLowExp = lbaLowExp;
        next_lbaMidExp = lbaMidExp;
        next_lbaHighExp = lbaHighExp;
        next_secCount = secCount;
        next_secCountExp = secCountExp;
        if (regApply) begin
            next_status = fieldByte(frameWord[0], HFX_STATUS_LSB);
            next_altStatus = fieldByte(frameWord[0], HFX_STATUS_LSB);
            next_shadowError = fieldByte(frameWord[0], HFX_ERROR_LSB);
            next_lbaLow = fieldByte(frameWord[1], HFX_BYTE0_LSB);
            next_lbaMid = fieldByte(frameWord[1], HFX_BYTE1_LSB);
            next_lbaHigh = fieldByte(frameWord[1], HFX_BYTE2_LSB);
            next_device = fieldByte(frameWord[1], HFX_BYTE3_LSB);
            next_lbaLowExp = fieldByte(frameWord[2], HFX_BYTE0_LSB);
            next_lbaMidExp = fieldByte(frameWord[2], HFX_BYTE1_LSB);
            next_lbaHighExp = fieldByte(frameWord[2], HFX_BYTE2_LSB);
            next_secCount = fieldByte(frameWord[3], HFX_BYTE0_LSB);
            next_secCountExp = fieldByte(frameWord[3], HFX_BYTE1_LSB);
        end else if (setBitsApply) begin
            next_shadowError = fieldByte(frameWord[0], HFX_ERROR_LSB);
            next_status = (status & ~HFX_SET_BITS_MASK) | setBitsStatus;
            next_altStatus = next_status;
        end else if (swStatusWrite) begin
            // Command issue by software loads the written status byte into both copies
            next_status = regWdata[7:0];
            next_altStatus = regWdata[7:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status <= HFX_STATUS_RESET;
            altStatus <= HFX_STATUS_RESET;
            shadowError <= 8'h00;
            lbaLow <= 8'h00;
            lbaMid <= 8'h00;
            lbaHigh <= 8'h00;
            device <= 8'h00;
            lbaLowExp <= 8'h00;
            lbaMidExp <= 8'h00;
            lbaHighExp <= 8'h00;
            secCount <= 8'h00;
            secCountExp <= 8'h00;
        end else begin
            status <= next_status;
            altStatus <= next_altStatus;
            shadowError <= next_shadowError;
            lbaLow <= next_lbaLow;
            lbaMid <= next_lbaMid;
            lbaHigh <= next_lbaHigh;
            device <= next_device;
            lbaLowExp <= next_lbaLowExp;
            lbaMidExp <= next_lbaMidExp;
            lbaHighExp <= next_lbaHighExp;
            secCount <= next_secCount;
            secCountExp <= next_secCountExp;
        end
    end

    // ----------------------------------------------------------------
    // Handshake, interrupt pending and refused-frame count
    // ----------------------------------------------------------------
    logic intSet, intClear, armWrite;
    logic next_rxOk, next_rxErr, next_intPending;
    logic [7:0] refused, next_refused;

    always_comb begin
        intSet = (setBitsApply && frameWord[0][HFX_INT_BIT] && shadowIdle)
                 || (regApply && frameWord[0][HFX_INT_BIT]);
        intClear = regWr && (regAddr == HFX_REG_CONTROL) && regWdata[HFX_CTL_CLR_INT_BIT];
        armWrite = regWr && (regAddr == HFX_REG_CONTROL) && regWdata[HFX_CTL_ARM_BIT];
        next_intPending = (intPending && !intClear) || intSet;
        next_rxOk = frameDone && frameGood;
        next_rxErr = frameDone && !frameGood;
        next_refused = refused + {7'h0, next_rxErr};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxOk <= 1'b0;
            rxErr <= 1'b0;
            intPending <= 1'b0;
            refused <= 8'h00;
        end else begin
            rxOk <= next_rxOk;
            rxErr <= next_rxErr;
            intPending <= next_intPending;
            refused <= next_refused;
        end
    end

    // ----------------------------------------------------------------
    // Data frame launch
    // ----------------------------------------------------------------
    logic armed, actPending;

    hfx_dma_launcher u_launcher (
        .clk(clk),
        .rst(rst),
        .actEvent(actEvent),
        .armWrite(armWrite),
        .dataFisAck(dataFisAck),
        .dataFisReq(dataFisReq),
        .armed(armed),
        .actPending(actPending)
    );

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    logic [31:0] next_regRdata;

    always_comb begin
        next_regRdata = 32'h0;
        if (regRd) begin
            case (regAddr)
                HFX_REG_STATUS: next_regRdata = {24'h0, status};
                HFX_REG_ALT_STATUS: next_regRdata = {24'h0, altStatus};
                HFX_REG_ERROR: next_regRdata = {24'h0, shadowError};
                HFX_REG_ADDRESS: next_regRdata = {device, lbaHigh, lbaMid, lbaLow};
                HFX_REG_ADDRESS_EXP: next_regRdata = {8'h0, lbaHighExp, lbaMidExp, lbaLowExp};
                HFX_REG_COUNT: next_regRdata = {16'h0, secCountExp, secCount};
                HFX_REG_FLAGS: next_regRdata = {28'h0, dataFisReq, armed, actPending, intPending};
                HFX_REG_REFUSED: next_regRdata = {24'h0, refused};
                default: next_regRdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdata <= 32'h0;
        end else begin
            regRdata <= next_regRdata;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_ALT_FOLLOWS_STATUS: assert property (@(posedge clk) disable iff (rst)
        regApply |=> (altStatus == status && status == $past(frameWord[0][23:16])))
        else $error("register frame status not in both status copies");
    AST_REG_COPIES_FIELDS: assert property (@(posedge clk) disable iff (rst)
        regApply |=> (shadowError == $past(frameWord[0][31:24]) && secCount == $past(frameWord[3][7:0])
                      && device == $past(frameWord[1][31:24])))
        else $error("register frame fields not copied");
    AST_IDLE_DROPS_REG: assert property (@(posedge clk) disable iff (rst)
        (frameDone && isReg && shadowIdle) |=> ($stable(shadowError) && $stable(lbaLow) && $stable(status)))
        else $error("register frame applied while not busy");
    AST_SET_BITS_KEEPS: assert property (@(posedge clk) disable iff (rst)
        setBitsApply |=> (status[7] == $past(status[7]) && status[3] == $past(status[3])))
        else $error("set-bits frame changed busy or request");
    AST_SET_BITS_LOADS: assert property (@(posedge clk) disable iff (rst)
        setBitsApply |=> (status[6:4] == $past(frameWord[0][22:20]) && status[2:0] == $past(frameWord[0][18:16])))
        else $error("set-bits status fields not loaded");
    AST_SET_BITS_INT: assert property (@(posedge clk) disable iff (rst)
        (setBitsApply && frameWord[0][HFX_INT_BIT] && shadowIdle) |=> intPending)
        else $error("set-bits interrupt not raised");
    AST_BAD_FRAME_ERR: assert property (@(posedge clk) disable iff (rst)
        (frameDone && !frameGood) |=> (rxErr && !rxOk) ##1 (!rxErr || $past(frameDone && !frameGood)))
        else $error("unknown frame not answered with error");
    AST_REFUSED_COUNTS: assert property (@(posedge clk) disable iff (rst)
        (frameDone && !frameGood) |=> (refused == $past(refused) + 8'h01))
        else $error("refused frame not counted");
    AST_REFUSED_KEEPS: assert property (@(posedge clk) disable iff (rst)
        (frameDone && !frameGood) |=> ($stable(shadowError) && $stable(lbaLow) && $stable(secCount) && $stable(device)))
        else $error("refused frame changed shadow registers");
    AST_ACT_KEEPS_SHADOW: assert property (@(posedge clk) disable iff (rst)
        actEvent |=> (rxOk && $stable(shadowError) && $stable(lbaLow) && $stable(secCount)))
        else $error("activate frame not accepted cleanly");
    AST_SET_BITS_ALT: assert property (@(posedge clk) disable iff (rst)
        setBitsApply |=> (altStatus == status))
        else $error("alternate status lost set-bits update");
    AST_SET_BITS_OK: assert property (@(posedge clk) disable iff (rst)
        (frameDone && isSetBits) |=> (rxOk && !rxErr))
        else $error("valid set-bits frame not acknowledged");
    AST_GOOD_FRAME_OK: assert property (@(posedge clk) disable iff (rst)
        (frameDone && frameWord[0][7:0] == HFX_TYPE_REG_D2H && frameLen == HFX_LEN_REG_D2H && !frameOver)
        |=> (rxOk && !rxErr))
        else $error("valid register frame not acknowledged");
endmodule : hfx_host_transport
`default_nettype wire

// *** test/hfx_dev_model.sv ***
// Device-side frame source and data frame acceptor
`timescale 1ns/1ns
`default_nettype none
module hfx_dev_model (
    // Clock
    input wire logic clk,
    // Frame stream to the host
    output logic rxValid = 1'b0,
    output logic rxSof = 1'b0,
    output logic rxEof = 1'b0,
    output logic [31:0] rxData = 32'h0,
    // Host data frame handshake
    input wire logic dataFisReq,
    output logic dataFisAck = 1'b0
);
    int slowAck = 0;
    int waitCnt = 0;

    // Sends one frame, type code placed in the low byte of the first word
    task automatic sendFrame(input logic [7:0] code, input int n, input logic [31:0] w [5]);
        w[0][7:0] = code;
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            rxValid <= 1'b1;
            rxSof <= (k == 0);
            rxEof <= (k == n - 1);
            rxData <= w[k];
        end
        @(posedge clk);
        rxValid <= 1'b0;
        rxSof <= 1'b0;
        rxEof <= 1'b0;
        rxData <= ~w[n - 1];
    endtask : sendFrame

    // Always ready to take the host data frame, after a chosen delay
    always @(posedge clk) begin
        dataFisAck <= 1'b0;
        if (dataFisReq === 1'b1 && !dataFisAck) begin
            waitCnt <= waitCnt + 1;
            if (waitCnt >= slowAck) begin
                dataFisAck <= 1'b1;
                waitCnt <= 0;
            end
        end
    end
endmodule : hfx_dev_model
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the host transport block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb;
    import hfx_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rxValid, rxSof, rxEof, rxOk, rxErr, dataFisReq, dataFisAck, intPending;
    logic [31:0] rxData, regRdata, fr [5];
    logic [31:0] rnd = 32'hc;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0, regRd = 1'b0, prevReq = 1'b0;
    logic [7:0] stat;
    int fail_count = 0, cmp_count = 0, okCount = 0, errCount = 0, reqCount = 0;
    logic [7:0] badCode [4] = '{8'h27, 8'h34, 8'ha1, 8'h39};
    int badLen [4] = '{1, 2, 1, 2};

    always #4 clk = ~clk;
    always @(posedge clk) begin
        okCount += (rxOk === 1'b1);
        errCount += (rxErr === 1'b1);
        reqCount += (dataFisReq === 1'b1 && prevReq !== 1'b1);
        prevReq = dataFisReq;
    end

    hfx_host_transport hfx_host_transport_i (.clk(clk), .rst(rst), .rxValid(rxValid), .rxSof(rxSof),
        .rxEof(rxEof), .rxData(rxData), .rxOk(rxOk), .rxErr(rxErr), .dataFisReq(dataFisReq),
        .dataFisAck(dataFisAck), .intPending(intPending), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
    hfx_dev_model hfx_dev_model_i (.clk(clk), .rxValid(rxValid), .rxSof(rxSof), .rxEof(rxEof),
        .rxData(rxData), .dataFisReq(dataFisReq), .dataFisAck(dataFisAck));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [7:0] setBitsStatus(input logic [7:0] old, input logic [7:0] fld);
        return (old & 8'h88) | (fld & 8'h77);
    endfunction : setBitsStatus

    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : regWrite
    task automatic regCheck(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 `CHK("register", e, regRdata)
    endtask : regCheck
    task automatic frame(input logic [7:0] code, input int n);
        hfx_dev_model_i.sendFrame(code, n, fr);
        repeat (4) @(posedge clk);
    endtask : frame
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict

    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        regCheck(HFX_REG_FLAGS, 32'h0);
        // Register frame while the shadow is idle is dropped
        rnd = lfsr(rnd);
        fr = '{{rnd[31:16], 16'h0}, rnd, 32'h0, 32'h0, 32'h0};
        frame(HFX_TYPE_REG_D2H, 5);
        regCheck(HFX_REG_ERROR, 32'h0);
        regCheck(HFX_REG_STATUS, 32'h0);
        // Busy command: register frame copies every field
        regWrite(HFX_REG_STATUS, 32'h80);
        for (int k = 0; k < 5; k++) begin
            rnd = lfsr(rnd);
            fr[k] = rnd;
        end
        fr[0][15:8] = 8'h00;
        fr[2][31:24] = 8'h00;
        fr[3][31:16] = 16'h0;
        fr[4] = 32'h0;
        frame(HFX_TYPE_REG_D2H, 5);
        stat = fr[0][23:16];
        regCheck(HFX_REG_STATUS, {24'h0, stat});
        regCheck(HFX_REG_ALT_STATUS, {24'h0, stat});
        regCheck(HFX_REG_ERROR, {24'h0, fr[0][31:24]});
        regCheck(HFX_REG_ADDRESS, fr[1]);
        regCheck(HFX_REG_ADDRESS_EXP, {8'h0, fr[2][23:0]});
        regCheck(HFX_REG_COUNT, {16'h0, fr[3][15:0]});
        `CHK("okCount", 2, okCount)
        // Set-bits with busy and request set, then both clear
        for (int j = 0; j < 2; j++) begin
            stat = (j == 0) ? 8'h88 : 8'h00;
            regWrite(HFX_REG_STATUS, {24'h0, stat});
            rnd = lfsr(rnd);
            fr = '{{rnd[31:24], rnd[23:16] | 8'h88, 8'h40, 8'h00}, 32'h0, 32'h0, 32'h0, 32'h0};
            frame(HFX_TYPE_SET_BITS, 2);
            regCheck(HFX_REG_STATUS, {24'h0, setBitsStatus(stat, rnd[23:16])});
            regCheck(HFX_REG_ERROR, {24'h0, rnd[31:24]});
            `CHK("intPending", (j == 1), intPending)
        end
        regWrite(HFX_REG_CONTROL, 32'h2);
        regCheck(HFX_REG_FLAGS, 32'h0);
        // Wrong codes and lengths are refused
        for (int j = 0; j < 4; j++) frame(badCode[j], badLen[j]);
        regCheck(HFX_REG_REFUSED, 32'h4);
        `CHK("errCount", 4, errCount)
        // Activation before arming is remembered
        hfx_dev_model_i.slowAck = 3;
        frame(HFX_TYPE_DMA_ACT, 1);
        regCheck(HFX_REG_FLAGS, 32'h2);
        `CHK("reqCount", 0, reqCount)
        regWrite(HFX_REG_CONTROL, 32'h1);
        repeat (3) @(posedge clk);
        `CHK("reqCount", 1, reqCount)
        repeat (8) @(posedge clk);
        regCheck(HFX_REG_FLAGS, 32'h0);
        // Armed first, activation launches at once
        hfx_dev_model_i.slowAck = 0;
        regWrite(HFX_REG_CONTROL, 32'h1);
        frame(HFX_TYPE_DMA_ACT, 1);
        `CHK("reqCount", 2, reqCount)
        // Arming alone does not launch another data frame
        regWrite(HFX_REG_CONTROL, 32'h1);
        repeat (6) @(posedge clk);
        `CHK("reqCount", 2, reqCount)
        regCheck(HFX_REG_FLAGS, 32'h4);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
